//--- verilog/cio_regs.svh
// Register offsets, field masks and reset values of the configurable I/O ports
`ifndef CIO_REGS_SVH
`define CIO_REGS_SVH
// ----------------------------------------------------------------------------
// Address layout: REG_ADDR[5:4] is the port, REG_ADDR[3:0] the register
// ----------------------------------------------------------------------------
`define CIO_PORT_A   2'h0
`define CIO_PORT_B   2'h1
`define CIO_PORT_C   2'h2
`define CIO_PORT_D   2'h3
`define CIO_REG_DIN  4'h0
`define CIO_REG_DOUT 4'h1
`define CIO_REG_CTRL 4'h2
`define CIO_REG_DIR  4'h3
`define CIO_REG_DRV  4'h4
`define CIO_REG_OMC  4'h5
`define CIO_REG_MASK 4'h6
`define CIO_REG_IMC  4'h7
`define CIO_REG_ENO  4'h8
// ----------------------------------------------------------------------------
// Field masks and reset value
// ----------------------------------------------------------------------------
`define CIO_CFG_RST  8'h00
`define CIO_OD_AB    8'hf0
`define CIO_SLEW_AB  8'h0f
`define CIO_OD_C     8'hff
`define CIO_SLEW_D   8'h06
`define CIO_USED_D   8'h06
`define CIO_JTAG_C   8'h9c
`define CIO_BIT_CLK  1
`define CIO_BIT_CS   2
`endif

//--- verilog/cio_pkg.sv
// Types shared by the configurable I/O port files
package cio_pkg;
	// Registered drive of one eight-pin port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] fast;
	} cio_drv_t;
endpackage : cio_pkg

//--- verilog/cio_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module cio_sync #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	// Data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta;
	// First stage is read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			dout <= '0;
		end else if (ce) begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule : cio_sync
`default_nettype wire

//--- verilog/cio_driver.sv
// Registered pin driver with open-drain and slew selection
`timescale 1ns/1ps
`default_nettype none
module cio_driver (
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      rst_n,
	input  wire logic      ce,
	// Requested drive
	input  wire logic [7:0] data,
	input  wire logic [7:0] en,
	input  wire logic [7:0] od,
	input  wire logic [7:0] fast,
	// Pin side
	output var cio_pkg::cio_drv_t drv
);
	import cio_pkg::*;
	// Open drain pulls low only; a high is left to the external pull-up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drv <= '0;
		end else if (ce) begin
			drv.out  <= data & ~od;
			drv.oe   <= en & (~od | ~data);
			drv.fast <= fast;
		end
	end
endmodule : cio_driver
`default_nettype wire

//--- verilog/cio_ports.sv
// Configurable I/O ports: registers, pin muxing, macrocell access
`timescale 1ns/1ps
`default_nettype none
`include "cio_regs.svh"
// Function
// - Enable status bit reads 1 when driving
// - Enable status only on ports A to C
// - Ports A,B: high nibble drain, low slew
// - Port C: all drive bits open drain
// - Port D: drive bits 2,1 select slew
// - Macrocell location reads outputs, writes load
// - Mask bits block macrocell loads
// - Input cell location reads input cells
// - Shared cell groups route between ports
// - Peripheral mode on port A only
// - Port C has no control register
// - JTAG pins on port C dedicated
// - Port D uses bits 2 and 1
// - Port D inputs feed logic directly
// - Lower D pin clocks cells, power-down
// - Upper D pin high disables module
// - Two selects, one term, chosen polarity
// - Select enable: term or direction bit
// - Output when direction or term set
// - Data out drives pins, reads back
// - Configuration resets to zero
module cio_ports (
	// Clock, reset, enable
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic        CE,
	// MCU register access
	input  wire logic        REG_CS,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [5:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	// Pins
	input  wire logic [7:0]  PA_IN,
	input  wire logic [7:0]  PB_IN,
	input  wire logic [7:0]  PC_IN,
	input  wire logic [7:0]  PD_IN,
	output var cio_pkg::cio_drv_t PA_DRV,
	output var cio_pkg::cio_drv_t PB_DRV,
	output var cio_pkg::cio_drv_t PC_DRV,
	output var cio_pkg::cio_drv_t PD_DRV,
	// Programmed configuration
	input  wire logic        ROUTE_AB_TO_B,
	input  wire logic        ROUTE_BC_TO_C,
	input  wire logic [7:0]  PA_LOGIC_SEL,
	input  wire logic [7:0]  PB_LOGIC_SEL,
	input  wire logic [7:0]  PC_LOGIC_SEL,
	input  wire logic        PERIPH_MODE,
	input  wire logic        JTAG_ISP_EN,
	input  wire logic        LOGIC_CLK_MODE,
	input  wire logic        CHIP_SEL_MODE,
	input  wire logic [1:0]  ECS_ENABLE,
	input  wire logic [1:0]  ECS_POLARITY,
	// Logic array side
	input  wire logic [7:0]  OE_TERM_A,
	input  wire logic [7:0]  OE_TERM_B,
	input  wire logic [7:0]  OE_TERM_C,
	input  wire logic [7:0]  OE_TERM_D,
	input  wire logic [7:0]  CELL_AB_D,
	input  wire logic [7:0]  CELL_BC_D,
	input  wire logic [7:0]  CELL_IN_A,
	input  wire logic [7:0]  CELL_IN_B,
	input  wire logic [7:0]  CELL_IN_C,
	input  wire logic [1:0]  ECS_TERM,
	input  wire logic [7:0]  LATCHED_ADDR,
	input  wire logic [7:0]  PERIPH_DATA,
	input  wire logic [7:0]  PERIPH_OE,
	// Results toward the logic array and memories
	output logic      [7:0]  CELL_AB_Q,
	output logic      [7:0]  CELL_BC_Q,
	output logic      [1:0]  D_TO_LOGIC,
	output logic             APD_CLK_TICK,
	output logic             MODULE_DISABLE
);
	import cio_pkg::*;

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	logic [7:0] dout [4];
	logic [7:0] dir  [4];
	logic [7:0] drv  [4];
	logic [7:0] ctrl [2];
	logic [7:0] mask_ab;
	logic [7:0] mask_bc;
	logic [7:0] sa, sb, sc, sd;
	logic       clk_prev;
	logic [7:0] next_rdata;
	logic [7:0] oe_a, oe_b, oe_c, oe_d;
	logic [7:0] out_a, out_b, out_c, out_d;
	logic [7:0] cells_b, ecs_val_d, din_c;
	logic [1:0] port;
	logic [3:0] rsel;
	logic       acc, wr, rd, tick, b_gets_ab;

	// ------------------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------------------
	cio_sync #(.W(8)) u_sa (.clk(CLK_SYS), .rst_n(RST_N), .ce(CE), .din(PA_IN), .dout(sa));
	cio_sync #(.W(8)) u_sb (.clk(CLK_SYS), .rst_n(RST_N), .ce(CE), .din(PB_IN), .dout(sb));
	cio_sync #(.W(8)) u_sc (.clk(CLK_SYS), .rst_n(RST_N), .ce(CE), .din(PC_IN), .dout(sc));
	cio_sync #(.W(8)) u_sd (.clk(CLK_SYS), .rst_n(RST_N), .ce(CE), .din(PD_IN), .dout(sd));

	// ------------------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------------------
	// A deselected module ignores every register access
	assign acc  = REG_CS & ~MODULE_DISABLE;
	assign wr   = acc & REG_WR;
	assign rd   = acc & REG_RD;
	assign port = REG_ADDR[5:4];
	assign rsel = REG_ADDR[3:0];
	assign b_gets_ab = ROUTE_AB_TO_B;
	// Edge of the logic clock taken from the settled sync stage only
	assign tick = LOGIC_CLK_MODE & sd[`CIO_BIT_CLK] & ~clk_prev;

	// Configuration registers; port D keeps only its two pin bits
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < 4; i++) begin
				dout[i] <= `CIO_CFG_RST;
				dir[i]  <= `CIO_CFG_RST;
				drv[i]  <= `CIO_CFG_RST;
			end
			ctrl[0] <= `CIO_CFG_RST;
			ctrl[1] <= `CIO_CFG_RST;
		end else if (CE && wr) begin
			case (rsel)
				`CIO_REG_DOUT: begin
					dout[port] <= (port == `CIO_PORT_D) ? (REG_WDATA & `CIO_USED_D) : REG_WDATA;
				end
				`CIO_REG_DIR: begin
					dir[port] <= (port == `CIO_PORT_D) ? (REG_WDATA & `CIO_USED_D) : REG_WDATA;
				end
				`CIO_REG_DRV: begin
					drv[port] <= (port == `CIO_PORT_D) ? (REG_WDATA & `CIO_SLEW_D) : REG_WDATA;
				end
				`CIO_REG_CTRL: begin
					// Address-out control exists on ports A and B only
					if (port == `CIO_PORT_A || port == `CIO_PORT_B) begin
						ctrl[port[0]] <= REG_WDATA;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Mask registers follow the cell group seen at each port's location
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			mask_ab <= `CIO_CFG_RST;
			mask_bc <= `CIO_CFG_RST;
		end else if (CE && wr && rsel == `CIO_REG_MASK) begin
			if (port == `CIO_PORT_A || (port == `CIO_PORT_B && b_gets_ab)) begin
				mask_ab <= REG_WDATA;
			end
			if (port == `CIO_PORT_C || (port == `CIO_PORT_B && !b_gets_ab)) begin
				mask_bc <= REG_WDATA;
			end
		end
	end

	// Output cell flip-flops: MCU load beats the logic clock on unmasked bits
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CELL_AB_Q <= `CIO_CFG_RST;
			CELL_BC_Q <= `CIO_CFG_RST;
		end else if (CE) begin
			for (int i = 0; i < 8; i++) begin
				if (wr && rsel == `CIO_REG_OMC && !mask_ab[i] &&
				    (port == `CIO_PORT_A || (port == `CIO_PORT_B && b_gets_ab))) begin
					CELL_AB_Q[i] <= REG_WDATA[i];
				end else if (tick) begin
					CELL_AB_Q[i] <= CELL_AB_D[i];
				end
				if (wr && rsel == `CIO_REG_OMC && !mask_bc[i] &&
				    (port == `CIO_PORT_C || (port == `CIO_PORT_B && !b_gets_ab))) begin
					CELL_BC_Q[i] <= REG_WDATA[i];
				end else if (tick) begin
					CELL_BC_Q[i] <= CELL_BC_D[i];
				end
			end
		end
	end

	// Port D dedicated inputs: clock tick, chip select, direct logic feed
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			clk_prev       <= 1'b0;
			APD_CLK_TICK   <= 1'b0;
			MODULE_DISABLE <= 1'b0;
			D_TO_LOGIC     <= 2'h0;
		end else if (CE) begin
			clk_prev       <= sd[`CIO_BIT_CLK];
			APD_CLK_TICK   <= tick;
			MODULE_DISABLE <= CHIP_SEL_MODE & sd[`CIO_BIT_CS];
			D_TO_LOGIC     <= {sd[`CIO_BIT_CS], sd[`CIO_BIT_CLK]};
		end
	end

	// ------------------------------------------------------------------------
	// Pin direction and data selection
	// ------------------------------------------------------------------------
	always_comb begin
		cells_b = b_gets_ab ? CELL_AB_Q : (ROUTE_BC_TO_C ? 8'h00 : CELL_BC_Q);
		// Direction bit OR enable term; peripheral mode owns port A
		oe_a = PERIPH_MODE ? PERIPH_OE : (dir[0] | OE_TERM_A);
		oe_b = dir[1] | OE_TERM_B;
		// ISP pins are never driven by the port while programming owns them
		oe_c = (dir[2] | OE_TERM_C) & ~(JTAG_ISP_EN ? `CIO_JTAG_C : 8'h00);
		// Pins used as clock or select inputs never drive
		oe_d = (dir[3] | OE_TERM_D) & `CIO_USED_D;
		if (LOGIC_CLK_MODE) oe_d[`CIO_BIT_CLK] = 1'b0;
		if (CHIP_SEL_MODE)  oe_d[`CIO_BIT_CS]  = 1'b0;
		// Latched address per bit, then logic output, else data out
		out_a = PERIPH_MODE ? PERIPH_DATA :
		        ((ctrl[0] & LATCHED_ADDR) |
		        (~ctrl[0] & ~PA_LOGIC_SEL & dout[0]) |
		        (~ctrl[0] & PA_LOGIC_SEL & (b_gets_ab ? 8'h00 : CELL_AB_Q)));
		out_b = (ctrl[1] & LATCHED_ADDR) | (~ctrl[1] & ~PB_LOGIC_SEL & dout[1]) |
		        (~ctrl[1] & PB_LOGIC_SEL & cells_b);
		out_c = (~PC_LOGIC_SEL & dout[2]) |
		        (PC_LOGIC_SEL & (ROUTE_BC_TO_C ? CELL_BC_Q : 8'h00));
		// Each select is one term with its own polarity
		ecs_val_d = 8'h00;
		for (int i = 0; i < 2; i++) begin
			ecs_val_d[i+1] = ECS_POLARITY[i] ? ECS_TERM[i] : ~ECS_TERM[i];
		end
		out_d = dout[3];
		for (int i = 1; i < 3; i++) begin
			if (ECS_ENABLE[i-1]) out_d[i] = ecs_val_d[i];
		end
		din_c = sc & ~(JTAG_ISP_EN ? `CIO_JTAG_C : 8'h00);
	end

	// ------------------------------------------------------------------------
	// Drivers; open drain on A/B high nibble and all of C, slew elsewhere
	// ------------------------------------------------------------------------
	cio_driver u_da (.clk(CLK_SYS), .rst_n(RST_N), .ce(CE), .data(out_a), .en(oe_a),
		.od(drv[0] & `CIO_OD_AB), .fast(drv[0] & `CIO_SLEW_AB), .drv(PA_DRV));
	cio_driver u_db (.clk(CLK_SYS), .rst_n(RST_N), .ce(CE), .data(out_b), .en(oe_b),
		.od(drv[1] & `CIO_OD_AB), .fast(drv[1] & `CIO_SLEW_AB), .drv(PB_DRV));
	cio_driver u_dc (.clk(CLK_SYS), .rst_n(RST_N), .ce(CE), .data(out_c), .en(oe_c),
		.od(drv[2] & `CIO_OD_C), .fast(8'h00), .drv(PC_DRV));
	cio_driver u_dd (.clk(CLK_SYS), .rst_n(RST_N), .ce(CE), .data(out_d), .en(oe_d),
		.od(8'h00), .fast(drv[3] & `CIO_SLEW_D), .drv(PD_DRV));

	// ------------------------------------------------------------------------
	// Read mux; unmapped locations read zero
	// ------------------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		case (rsel)
			`CIO_REG_DIN: begin
				case (port)
					`CIO_PORT_A: next_rdata = sa;
					`CIO_PORT_B: next_rdata = sb;
					`CIO_PORT_C: next_rdata = din_c;
					default:     next_rdata = sd & `CIO_USED_D;
				endcase
			end
			`CIO_REG_DOUT: next_rdata = dout[port];
			`CIO_REG_DIR:  next_rdata = dir[port];
			`CIO_REG_DRV:  next_rdata = drv[port];
			`CIO_REG_CTRL: next_rdata = port[1] ? 8'h00 : ctrl[port[0]];
			`CIO_REG_OMC: begin
				case (port)
					`CIO_PORT_A: next_rdata = CELL_AB_Q;
					`CIO_PORT_B: next_rdata = b_gets_ab ? CELL_AB_Q : CELL_BC_Q;
					`CIO_PORT_C: next_rdata = CELL_BC_Q;
					default:     next_rdata = 8'h00;
				endcase
			end
			`CIO_REG_MASK: begin
				case (port)
					`CIO_PORT_A: next_rdata = mask_ab;
					`CIO_PORT_B: next_rdata = b_gets_ab ? mask_ab : mask_bc;
					`CIO_PORT_C: next_rdata = mask_bc;
					default:     next_rdata = 8'h00;
				endcase
			end
			`CIO_REG_IMC: begin
				case (port)
					`CIO_PORT_A: next_rdata = CELL_IN_A;
					`CIO_PORT_B: next_rdata = CELL_IN_B;
					`CIO_PORT_C: next_rdata = CELL_IN_C;
					default:     next_rdata = 8'h00;
				endcase
			end
			`CIO_REG_ENO: begin
				// Effective enable before open-drain shaping
				case (port)
					`CIO_PORT_A: next_rdata = oe_a;
					`CIO_PORT_B: next_rdata = oe_b;
					`CIO_PORT_C: next_rdata = oe_c;
					default:     next_rdata = 8'h00;
				endcase
			end
			default: next_rdata = 8'h00;
		endcase
	end

	// Read data holds until the next read strobe
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 8'h00;
		end else if (CE && rd) begin
			REG_RDATA <= next_rdata;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	chk_enout_value: assert property (CE && rd && rsel == `CIO_REG_ENO && port == `CIO_PORT_B
		|=> REG_RDATA == $past(oe_b)) else $error("enable status mismatch");
	chk_enout_portd: assert property (CE && rd && rsel == `CIO_REG_ENO && port == `CIO_PORT_D
		|=> REG_RDATA == 8'h00) else $error("port D enable status not zero");
	chk_ab_drain: assert property (CE && drv[0][7] && out_a[7]
		|=> !PA_DRV.oe[7]) else $error("open drain drove high");
	chk_c_drain: assert property (CE && drv[2][0] && oe_c[0] && !out_c[0]
		|=> PC_DRV.oe[0] && !PC_DRV.out[0]) else $error("port C drain not pulling low");
	chk_d_slew: assert property (CE |=> PD_DRV.fast == ($past(drv[3]) & `CIO_SLEW_D))
		else $error("port D slew wrong");
	chk_omc_load: assert property (CE && wr && rsel == `CIO_REG_OMC && port == `CIO_PORT_A
		&& !b_gets_ab && mask_ab == 8'h00 |=> CELL_AB_Q == $past(REG_WDATA))
		else $error("macrocell load missed");
	chk_mask_block: assert property (CE && !tick && mask_ab == 8'hff
		|=> $stable(CELL_AB_Q)) else $error("masked cell loaded");
	chk_dir_drive: assert property (CE && dir[1][0] && !ctrl[1][0] && !PB_LOGIC_SEL[0]
		|=> PB_DRV.oe[0]) else $error("direction bit ignored");
	chk_d_unused: assert property (((dout[3] | dir[3]) & ~`CIO_USED_D) == 8'h00)
		else $error("port D unused bit set");
	chk_cs_block: assert property (MODULE_DISABLE |=> $stable(dout[0]))
		else $error("write while deselected");
	chk_clk_tick: assert property (CE && tick ##1 CE |-> APD_CLK_TICK ##1 !APD_CLK_TICK)
		else $error("logic clock tick wrong");
	chk_reset_zero: assert property ($rose(RST_N) |-> drv[0] == 8'h00 && dir[2] == 8'h00)
		else $error("configuration not cleared");

	cov_omc_write: cover property (wr && rsel == `CIO_REG_OMC);
	cov_ecs_drive: cover property (ECS_ENABLE[0] && PD_DRV.oe[1]);
	cov_deselect:  cover property ($rose(MODULE_DISABLE));
endmodule : cio_ports
`default_nettype wire

//--- verification/cio_pin_model.sv
// Pin-side model: outside drivers, pull-ups and the resolved level of every port pin
`timescale 1ns/1ps
`default_nettype none
module cio_pin_model (
	// Device drive, one struct per port
	input  wire cio_pkg::cio_drv_t drv     [4],
	// Outside drivers, value and enable per pin
	input  wire logic [7:0]        ext_val [4],
	input  wire logic [7:0]        ext_en  [4],
	// Resolved pin levels
	output logic      [7:0]        pin     [4]
);
	import cio_pkg::*;
	// ------------------------------------------------------------------------
	// Pin resolution
	// ------------------------------------------------------------------------
	// Every line has a pull-up, so a released open-drain pin reads high;
	// the device wins a clash so that a bad enable shows up as a wrong level
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			pin[p] = (drv[p].oe & drv[p].out) | (~drv[p].oe & ext_en[p] & ext_val[p])
				| (~drv[p].oe & ~ext_en[p]);
		end
	end
endmodule : cio_pin_model
`default_nettype wire

//--- verification/configurable_io_ports_test.sv
// Self-checking bench for the configurable I/O ports, driven over the register bus
`timescale 1ns/1ps
`default_nettype none
`include "cio_regs.svh"
module configurable_io_ports_test;
	import cio_pkg::*;
	// ------------------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------------------
	logic       clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_cs = 1'b0, reg_wr = 1'b0;
	logic       reg_rd = 1'b0, route_ab = 1'b0, periph = 1'b0, jtag = 1'b0, route_bc = 1'b0;
	logic       clk_mode = 1'b0, cs_mode = 1'b0, apd_tick, mod_dis;
	logic [1:0] ecs_en = 2'h0, ecs_pol = 2'h0, ecs_term = 2'h0, d_to_logic;
	logic [5:0] reg_addr = 6'h00;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, sel_a = 8'h00, sel_b = 8'h00, sel_c = 8'h00;
	logic [7:0] cell_ab_d = 8'h00, periph_data = 8'hc3, periph_oe = 8'hf0, cell_ab_q;
	logic [7:0] cell_bc_q, lat_addr = 8'h00;
	logic [7:0] oe_t    [4] = '{8'h10, 8'h20, 8'h40, 8'h00};
	logic [7:0] cell_in [3] = '{8'h3c, 8'h5a, 8'h69};
	logic [7:0] ext_val [4] = '{default: 8'h00};
	logic [7:0] ext_en  [4] = '{default: 8'h00};
	logic [7:0] pin     [4];
	cio_drv_t   drv     [4];
	int         num_errors = 0, checks = 0, cycles = 0, ticks = 0;
	// Expected drive of each port with data a5, all outputs, all drive bits set
	logic [23:0] drv_exp [4] = '{24'h055f0f, 24'h055f0f, 24'h005a00, 24'h040606};

	// 100 MHz system clock
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	// Design and pin model; the next values of the second cell group are held at zero
	cio_ports dut (
		.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .REG_CS(reg_cs), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.PA_IN(pin[0]), .PB_IN(pin[1]), .PC_IN(pin[2]), .PD_IN(pin[3]),
		.PA_DRV(drv[0]), .PB_DRV(drv[1]), .PC_DRV(drv[2]), .PD_DRV(drv[3]),
		.ROUTE_AB_TO_B(route_ab), .ROUTE_BC_TO_C(route_bc), .PA_LOGIC_SEL(sel_a),
		.PB_LOGIC_SEL(sel_b), .PC_LOGIC_SEL(sel_c), .PERIPH_MODE(periph),
		.JTAG_ISP_EN(jtag), .LOGIC_CLK_MODE(clk_mode), .CHIP_SEL_MODE(cs_mode),
		.ECS_ENABLE(ecs_en), .ECS_POLARITY(ecs_pol), .OE_TERM_A(oe_t[0]),
		.OE_TERM_B(oe_t[1]), .OE_TERM_C(oe_t[2]), .OE_TERM_D(oe_t[3]),
		.CELL_AB_D(cell_ab_d), .CELL_BC_D(8'h00), .CELL_IN_A(cell_in[0]),
		.CELL_IN_B(cell_in[1]), .CELL_IN_C(cell_in[2]), .ECS_TERM(ecs_term),
		.LATCHED_ADDR(lat_addr), .PERIPH_DATA(periph_data), .PERIPH_OE(periph_oe),
		.CELL_AB_Q(cell_ab_q), .CELL_BC_Q(cell_bc_q), .D_TO_LOGIC(d_to_logic),
		.APD_CLK_TICK(apd_tick), .MODULE_DISABLE(mod_dis)
	);
	cio_pin_model pins (.drv(drv), .ext_val(ext_val), .ext_en(ext_en), .pin(pin));

	// ------------------------------------------------------------------------
	// Bus tasks and comparison
	// ------------------------------------------------------------------------
	// Every task starts and ends just after a rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	function automatic logic [5:0] ad(input int p, input logic [3:0] r);
		return {p[1:0], r};
	endfunction : ad

	task automatic check(input logic [23:0] s, input logic [23:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : check

	// Strobe drops for one full cycle so back-to-back calls never re-assign it in one step
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		{reg_cs, reg_wr, reg_rd} = 3'b110;
		reg_addr = a;
		reg_wdata = d;
		tick(1);
		{reg_cs, reg_wr, reg_rd} = 3'b000;
		tick(1);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		{reg_cs, reg_wr, reg_rd} = 3'b101;
		reg_addr = a;
		tick(1);
		{reg_cs, reg_wr, reg_rd} = 3'b000;
		tick(1);
		check(24'(reg_rdata), 24'(e));
	endtask : rd

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test

	// Hang guard and tick counter; the sequence needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (apd_tick === 1'b1)
			ticks++;
		if (cycles == 4000) begin
			num_errors++;
			stop_test();
		end
	end

	// ------------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		tick(1);
		// Reset values, then data out write and read back
		for (int p = 0; p < 4; p++) begin
			rd(ad(p, `CIO_REG_DIR), 8'h00);
			rd(ad(p, `CIO_REG_DRV), 8'h00);
			wr(ad(p, `CIO_REG_DOUT), 8'hff);
			rd(ad(p, `CIO_REG_DOUT), (p == 3) ? 8'h06 : 8'hff);
		end
		rd(ad(0, `CIO_REG_CTRL), 8'h00);
		// Enable status merges direction and product term; input cells read back
		for (int p = 0; p < 3; p++) begin
			wr(ad(p, `CIO_REG_DIR), 8'h01);
			rd(ad(p, `CIO_REG_ENO), 8'h01 | oe_t[p]);
			rd(ad(p, `CIO_REG_IMC), cell_in[p]);
		end
		rd(ad(3, `CIO_REG_ENO), 8'h00);
		rd(ad(3, `CIO_REG_OMC), 8'h00);
		rd(ad(2, `CIO_REG_CTRL), 8'h00);
		rd(ad(0, 4'h9), 8'h00);
		// Drive select per port
		for (int p = 0; p < 4; p++) begin
			wr(ad(p, `CIO_REG_DOUT), 8'ha5);
			wr(ad(p, `CIO_REG_DIR), 8'hff);
			wr(ad(p, `CIO_REG_DRV), 8'hff);
			tick(3);
			check(drv[p], drv_exp[p]);
		end
		rd(ad(3, `CIO_REG_DRV), 8'h06);
		rd(ad(3, `CIO_REG_DIR), 8'h06);
		rd(ad(0, `CIO_REG_ENO), 8'hff);
		// Port A as input: only the term-enabled open-drain pin pulls low
		wr(ad(0, `CIO_REG_DIR), 8'h00);
		ext_en[0] = 8'hff;
		ext_val[0] = 8'h3c;
		tick(4);
		rd(ad(0, `CIO_REG_DIN), 8'h2c);
		// Programming pins on port C stay released and read zero
		jtag = 1'b1;
		ext_en[2] = 8'hff;
		ext_val[2] = 8'hff;
		tick(4);
		check(24'(drv[2].oe & 8'h9c), 24'h0);
		rd(ad(2, `CIO_REG_DIN), 8'h21);
		jtag = 1'b0;
		// Output cells, load blocking and group routing
		wr(ad(0, `CIO_REG_MASK), 8'hf0);
		rd(ad(0, `CIO_REG_MASK), 8'hf0);
		wr(ad(0, `CIO_REG_OMC), 8'hff);
		rd(ad(0, `CIO_REG_OMC), 8'h0f);
		check(24'(cell_ab_q), 24'h0f);
		wr(ad(0, `CIO_REG_DRV), 8'h00);
		wr(ad(0, `CIO_REG_DIR), 8'hff);
		sel_a = 8'hff;
		sel_b = 8'hff;
		tick(3);
		check(drv[0], 24'h0fff00);
		route_ab = 1'b1;
		tick(3);
		check(drv[0], 24'h00ff00);
		check(drv[1], 24'h0fff0f);
		rd(ad(1, `CIO_REG_OMC), 8'h0f);
		// Peripheral mode moves port A only
		route_ab = 1'b0;
		sel_a = 8'h00;
		sel_b = 8'h00;
		periph = 1'b1;
		tick(3);
		check(24'(drv[0].out), 24'hc3);
		check(24'(drv[1].out), 24'h05);
		periph = 1'b0;
		// Frozen clock enable drops a write
		ce = 1'b0;
		wr(ad(1, `CIO_REG_DOUT), 8'h11);
		ce = 1'b1;
		rd(ad(1, `CIO_REG_DOUT), 8'ha5);
		// Port D inputs straight to the logic array, then module select
		wr(ad(3, `CIO_REG_DIR), 8'h00);
		ext_en[3] = 8'h06;
		ext_val[3] = 8'h04;
		tick(4);
		check(24'(d_to_logic), 24'h2);
		cs_mode = 1'b1;
		tick(3);
		check(24'(mod_dis), 24'h1);
		wr(ad(1, `CIO_REG_DOUT), 8'h00);
		ext_val[3] = 8'h00;
		tick(3);
		check(24'(mod_dis), 24'h0);
		rd(ad(1, `CIO_REG_DOUT), 8'ha5);
		cs_mode = 1'b0;
		// Lower pin as logic clock: two rising edges
		clk_mode = 1'b1;
		cell_ab_d = 8'h3c;
		repeat (2) begin
			ext_val[3] = 8'h02;
			tick(4);
			ext_val[3] = 8'h00;
			tick(4);
		end
		check(24'(ticks), 24'h2);
		check(24'(cell_ab_q), 24'h3c);
		clk_mode = 1'b0;
		// External selects: polarity, then enable from term and direction
		ext_en[3] = 8'h00;
		ecs_en = 2'h3;
		ecs_term = 2'h1;
		ecs_pol = 2'h1;
		tick(3);
		check(24'({drv[3].out & 8'h06, drv[3].oe & 8'h06}), 24'h0600);
		oe_t[3] = 8'h04;
		tick(3);
		check(24'({drv[3].out & 8'h06, drv[3].oe & 8'h06}), 24'h0604);
		wr(ad(3, `CIO_REG_DIR), 8'h02);
		ecs_pol = 2'h2;
		tick(3);
		check(24'({drv[3].out & 8'h06, drv[3].oe & 8'h06}), 24'h0006);
		// Second cell group through port B then port C, its mask, then address out
		wr(ad(2, `CIO_REG_OMC), 8'h5a);
		check(24'(cell_bc_q), 24'h5a);
		rd(ad(1, `CIO_REG_OMC), 8'h5a);
		sel_b = 8'hff;
		tick(3);
		check(drv[1], 24'h0aaf0f);
		route_bc = 1'b1;
		sel_c = 8'hff;
		tick(3);
		check(drv[2], 24'h00a500);
		check(24'(drv[1].out), 24'h00);
		wr(ad(1, `CIO_REG_MASK), 8'h0f);
		rd(ad(2, `CIO_REG_MASK), 8'h0f);
		wr(ad(2, `CIO_REG_OMC), 8'hff);
		rd(ad(2, `CIO_REG_OMC), 8'hfa);
		wr(ad(0, `CIO_REG_CTRL), 8'h0f);
		rd(ad(0, `CIO_REG_CTRL), 8'h0f);
		lat_addr = 8'h96;
		sel_a = 8'h30;
		tick(3);
		check(24'(drv[0].out), 24'hb6);
		wr(ad(0, `CIO_REG_MASK), 8'h00);
		wr(ad(0, `CIO_REG_OMC), 8'h81);
		rd(ad(0, `CIO_REG_OMC), 8'h81);
		stop_test();
	end
endmodule : configurable_io_ports_test
`default_nettype wire
